// ---- rtl/ctifc_regs.sv ----
// Purpose: Cycle timer, iso channel/tag filter and queue control registers behind an AHB-Lite slave.
// Assumes: One 50 MHz clock; external cycle pin is asynchronous; packet engines live elsewhere.
// Notes:   Zero wait-state slave; read data registered in the address phase.
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module ctifc_regs
  import ctifc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic            i_clk_sys,
  input  wire logic            i_rst_b,
  input  wire logic            i_ce,
  // AHB-Lite slave
  input  wire logic            i_hsel,
  input  wire logic [31:0]     i_haddr,
  input  wire logic [1:0]      i_htrans,
  input  wire logic            i_hwrite,
  input  wire logic [2:0]      i_hsize,
  input  wire logic [31:0]     i_hwdata,
  input  wire logic            i_hready,
  output logic [31:0]          o_hrdata,
  output logic                 o_hreadyout,
  output logic                 o_hresp,
  // Link side
  input  wire logic            i_ext_cycle,
  input  wire ctifc_cyc_load_t i_cycle_start,
  input  wire ctifc_iso_hdr_t  i_iso_hdr,
  // Results
  output logic                 o_iso_accept,
  output logic [1:0]           o_iso_port_hit,
  output logic                 o_flush_async_tx_queue,
  output logic                 o_flush_iso_tx_queue,
  output logic                 o_flush_rx_queue,
  output logic [11:0]          o_general_rx_queue_size,
  output logic [31:0]          o_bus_cycle_time,
  output logic                 o_cycle_tick
);

  // Register state.
  logic [31:0] bus_cycle_time_r;
  logic [31:0] bus_cycle_time_nxt;
  logic [31:0] iso_channel_filter_r;
  logic [31:0] queue_control_r;
  logic [31:0] control_r;
  logic [15:0] phase_acc_r;
  logic [15:0] phase_acc_nxt;

  // Bus pipeline.
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic        wr_word_r;

  // External cycle pin synchroniser.
  logic        ext_meta_r;
  logic        ext_sync_r;
  logic        ext_prev_r;

  function automatic logic [31:0] ctifc_read_mux(
    input logic [7:0]  addr,
    input logic [31:0] cyc,
    input logic [31:0] filt,
    input logic [31:0] queue,
    input logic [31:0] ctl,
    input logic [31:0] stat
  );
    logic [31:0] v;
    v = 32'h0000_0000;
    if (addr == CTIFC_OFS_CYCLE)
      v = cyc;
    else if (addr == CTIFC_OFS_FILTER)
      v = filt;
    else if (addr == CTIFC_OFS_QUEUE)
      v = queue & CTIFC_QUEUE_RW_MASK;
    else if (addr == CTIFC_OFS_CONTROL)
      v = ctl;
    else if (addr == CTIFC_OFS_STATUS)
      v = stat;
    return v;
  endfunction

  function automatic logic ctifc_port_match(
    input logic       en,
    input logic [5:0] ch_cfg,
    input logic [1:0] tag_cfg,
    input logic       tag_cmp,
    input logic [5:0] ch_in,
    input logic [1:0] tag_in
  );
    return en && (ch_cfg == ch_in) && (!tag_cmp || (tag_cfg == tag_in));
  endfunction

  // Address phase decode.
  wire         addr_valid  = i_hsel && i_hready && (i_htrans == CTIFC_HTRANS_NONSEQ || i_htrans == CTIFC_HTRANS_SEQ);
  wire         rd_take     = addr_valid && !i_hwrite;
  wire         wr_take     = addr_valid && i_hwrite;
  wire         wr_now      = wr_pend_r && wr_word_r;
  wire         wr_cycle    = wr_now && (wr_addr_r == CTIFC_OFS_CYCLE);
  wire         wr_filter   = wr_now && (wr_addr_r == CTIFC_OFS_FILTER);
  wire         wr_queue    = wr_now && (wr_addr_r == CTIFC_OFS_QUEUE);
  wire         wr_control  = wr_now && (wr_addr_r == CTIFC_OFS_CONTROL);

  // Control fields.
  wire         ct_enable   = control_r[CTIFC_CTL_CT_EN];
  wire         ct_master   = control_r[CTIFC_CTL_MASTER];
  wire         ct_source   = control_r[CTIFC_CTL_SOURCE];
  wire         accept_all_channels = control_r[CTIFC_CTL_ACCALL];

  // Cycle time fields.
  wire [6:0]   seconds_count = bus_cycle_time_r[CTIFC_SEC_LSB +: 7];
  wire [12:0]  cycle_count   = bus_cycle_time_r[CTIFC_CYC_LSB +: 13];
  wire [11:0]  cycle_offset  = bus_cycle_time_r[CTIFC_OFF_LSB +: 12];

  // Offset tick generation by phase accumulator.
  wire [16:0]  acc_sum     = {1'b0, phase_acc_r} + {1'b0, CTIFC_ACC_STEP};
  wire         off_tick    = acc_sum >= {1'b0, CTIFC_ACC_MOD};
  wire         ext_edge    = ext_sync_r && !ext_prev_r;
  wire         off_wrap    = cycle_offset == CTIFC_OFF_MAX;
  wire         cyc_wrap    = cycle_count == CTIFC_CYC_MAX;

  // With an external cycle source the pin, not the offset roll-over, closes a cycle.
  wire         cyc_carry   = ct_source ? ext_edge : (off_tick && off_wrap);

  always_comb
  begin
    phase_acc_nxt = off_tick ? 16'(acc_sum - {1'b0, CTIFC_ACC_MOD}) : acc_sum[15:0];
  end

  // Counting: offset 0..3071, cycle 0..7999, seconds 0..127.
  logic [11:0] off_nxt;
  logic [12:0] cyc_nxt;
  logic [6:0]  sec_nxt;

  always_comb
  begin
    off_nxt = cycle_offset;
    cyc_nxt = cycle_count;
    sec_nxt = seconds_count;
    if (ct_enable)
    begin
      if (cyc_carry)
        off_nxt = 12'h000;
      else if (off_tick && !ct_source)
        off_nxt = cycle_offset + 12'h001;
      else if (off_tick && ct_source && !off_wrap)
        off_nxt = cycle_offset + 12'h001;
      if (cyc_carry)
      begin
        cyc_nxt = cyc_wrap ? 13'h0000 : cycle_count + 13'h0001;
        if (cyc_wrap)
          sec_nxt = (seconds_count == CTIFC_SEC_MAX) ? 7'h00 : seconds_count + 7'h01;
      end
    end
  end

  // A host write wins over counting; a received cycle start loads an enabled non-master timer.
  always_comb
  begin
    bus_cycle_time_nxt = {sec_nxt, cyc_nxt, off_nxt};
    if (wr_cycle)
      bus_cycle_time_nxt = i_hwdata;
    else if (i_cycle_start.load && ct_enable && !ct_master)
      bus_cycle_time_nxt = i_cycle_start.time_val;
  end

  // Iso channel filter.
  wire [1:0]   port_one_format_tag = iso_channel_filter_r[CTIFC_PORT_ONE_FORMAT_TAG_LSB +: 2];
  wire [5:0]   port_one_channel    = iso_channel_filter_r[CTIFC_CH1_LSB +: 6];
  wire [1:0]   port_two_format_tag = iso_channel_filter_r[CTIFC_PORT_TWO_FORMAT_TAG_LSB +: 2];
  wire [5:0]   port_two_channel    = iso_channel_filter_r[CTIFC_CH2_LSB +: 6];
  wire         tag_compare_enable  = iso_channel_filter_r[CTIFC_TAG_COMPARE_ENABLE];
  wire         port_one_enable     = control_r[CTIFC_CTL_ACCALL + 1];
  wire         port_two_enable     = control_r[CTIFC_CTL_ACCALL + 2];

  wire         hit_one = ctifc_port_match(port_one_enable, port_one_channel, port_one_format_tag,
                                          tag_compare_enable, i_iso_hdr.channel, i_iso_hdr.tag);
  wire         hit_two = ctifc_port_match(port_two_enable, port_two_channel, port_two_format_tag,
                                          tag_compare_enable, i_iso_hdr.channel, i_iso_hdr.tag);
  wire         iso_ok  = i_iso_hdr.valid && (accept_all_channels || hit_one || hit_two);

  // Queue partition: what the transmit queues leave over goes to receive.
  wire [8:0]   atx_size  = queue_control_r[CTIFC_ATX_LSB +: 9];
  wire [8:0]   itx_size  = queue_control_r[CTIFC_ITX_LSB +: 9];
  wire [11:0]  tx_total  = {3'h0, atx_size} + {3'h0, itx_size};
  wire [11:0]  rx_size   = CTIFC_QUEUE_TOTAL - tx_total;

  wire [31:0]  status_word = {19'h00000, ext_sync_r, o_iso_port_hit, o_iso_accept, 1'b0, rx_size[7:0]};
  wire [31:0]  rd_word     = ctifc_read_mux(i_haddr[7:0], bus_cycle_time_r, iso_channel_filter_r,
                                            queue_control_r, control_r, status_word);

  // Bus slave registers.
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      wr_pend_r   <= 1'b0;
      wr_addr_r   <= 8'h00;
      wr_word_r   <= 1'b0;
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b0;
      o_hresp     <= 1'b0;
    end
    else if (i_ce)
    begin
      o_hreadyout <= 1'b1;
      wr_pend_r   <= wr_take;
      wr_addr_r   <= i_haddr[7:0];
      wr_word_r   <= (i_hsize == CTIFC_HSIZE_WORD) && (i_haddr[31:8] == 24'h000000);
      o_hrdata    <= rd_take ? rd_word : 32'h0000_0000;
    end
  end

  // Register file.
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      bus_cycle_time_r     <= CTIFC_RST_CYCLE;
      iso_channel_filter_r <= CTIFC_RST_FILTER;
      queue_control_r      <= CTIFC_RST_QUEUE;
      control_r            <= CTIFC_RST_CONTROL;
      phase_acc_r          <= 16'h0000;
    end
    else if (i_ce)
    begin
      bus_cycle_time_r <= bus_cycle_time_nxt;
      phase_acc_r      <= ct_enable ? phase_acc_nxt : 16'h0000;
      if (wr_filter)
        iso_channel_filter_r <= i_hwdata;
      if (wr_queue)
        queue_control_r <= i_hwdata & CTIFC_QUEUE_RW_MASK;
      if (wr_control)
        control_r <= i_hwdata & {26'h0000000, 6'h3F};
    end
  end

  // Flush strobes: the bits never hold a one, so reads see zero.
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_flush_async_tx_queue <= 1'b0;
      o_flush_iso_tx_queue   <= 1'b0;
      o_flush_rx_queue       <= 1'b0;
    end
    else if (i_ce)
    begin
      o_flush_async_tx_queue <= wr_queue && i_hwdata[CTIFC_FLUSH_ATX];
      o_flush_iso_tx_queue   <= wr_queue && i_hwdata[CTIFC_FLUSH_ITX];
      o_flush_rx_queue       <= wr_queue && i_hwdata[CTIFC_FLUSH_RX];
    end
  end

  // Filter result, timer view and pin synchroniser.
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_iso_accept            <= 1'b0;
      o_iso_port_hit          <= 2'h0;
      o_general_rx_queue_size <= 12'h000;
      o_bus_cycle_time        <= 32'h0000_0000;
      o_cycle_tick            <= 1'b0;
      ext_meta_r              <= 1'b0;
      ext_sync_r              <= 1'b0;
      ext_prev_r              <= 1'b0;
    end
    else if (i_ce)
    begin
      o_iso_accept            <= iso_ok;
      o_iso_port_hit          <= i_iso_hdr.valid ? {hit_two, hit_one} : 2'h0;
      o_general_rx_queue_size <= (tx_total > CTIFC_QUEUE_TOTAL) ? 12'h000 : rx_size;
      o_bus_cycle_time        <= bus_cycle_time_nxt;
      o_cycle_tick            <= ct_enable && cyc_carry && !wr_cycle;
      ext_meta_r              <= i_ext_cycle;
      ext_sync_r              <= ext_meta_r;
      ext_prev_r              <= ext_sync_r;
    end
  end

endmodule // ctifc_regs

`default_nettype wire

// ---- rtl/ctifc_pkg.sv ----
// Purpose: Shared constants and types for the cycle timer, iso filter and queue control register bank.
// Assumes: 32-bit AHB-Lite register bus, 50 MHz system clock.
// Notes:   Field positions are hardware bit indices (bit 31 is the most significant).
package ctifc_pkg;

  // Register byte offsets.
  localparam logic [7:0] CTIFC_OFS_CONTROL  = 8'h08;
  localparam logic [7:0] CTIFC_OFS_CYCLE    = 8'h14;
  localparam logic [7:0] CTIFC_OFS_FILTER   = 8'h18;
  localparam logic [7:0] CTIFC_OFS_QUEUE    = 8'h1C;
  localparam logic [7:0] CTIFC_OFS_STATUS   = 8'h2C;

  // Reset values.
  localparam logic [31:0] CTIFC_RST_CYCLE   = 32'h0000_0000;
  localparam logic [31:0] CTIFC_RST_FILTER  = 32'h0000_0000;
  localparam logic [31:0] CTIFC_RST_QUEUE   = 32'h07FD_3299;
  localparam logic [31:0] CTIFC_RST_CONTROL = 32'h0000_0000;

  // Cycle time fields: seconds [31:25], cycle [24:12], offset [11:0].
  localparam int CTIFC_SEC_LSB  = 25;
  localparam int CTIFC_CYC_LSB  = 12;
  localparam int CTIFC_OFF_LSB  = 0;
  localparam logic [6:0]  CTIFC_SEC_MAX = 7'h7F;
  localparam logic [12:0] CTIFC_CYC_MAX = 13'h1F3F;
  localparam logic [11:0] CTIFC_OFF_MAX = 12'hBFF;

  // Iso filter fields.
  localparam int CTIFC_PORT_ONE_FORMAT_TAG_LSB = 30;
  localparam int CTIFC_CH1_LSB  = 24;
  localparam int CTIFC_PORT_TWO_FORMAT_TAG_LSB = 22;
  localparam int CTIFC_CH2_LSB  = 16;
  localparam int CTIFC_TAG_COMPARE_ENABLE   = 0;

  // Queue control fields.
  localparam int CTIFC_FLUSH_ATX = 31;
  localparam int CTIFC_FLUSH_ITX = 30;
  localparam int CTIFC_FLUSH_RX  = 29;
  localparam int CTIFC_ATX_LSB   = 9;
  localparam int CTIFC_ITX_LSB   = 0;
  localparam logic [31:0] CTIFC_QUEUE_RW_MASK = 32'h07FF_FFFF;
  localparam logic [11:0] CTIFC_QUEUE_TOTAL   = 12'hA00;

  // Control register bits.
  localparam int CTIFC_CTL_CT_EN  = 0;
  localparam int CTIFC_CTL_MASTER = 1;
  localparam int CTIFC_CTL_SOURCE = 2;
  localparam int CTIFC_CTL_ACCALL = 3;
  localparam logic [31:0] CTIFC_CTL_RW_MASK = 32'h0000_000F;

  // Offset tick: 24.576 MHz from 50 MHz by phase accumulation, in kHz.
  localparam int CTIFC_SYS_KHZ = 50000;
  localparam int CTIFC_OFF_KHZ = 24576;
  localparam logic [15:0] CTIFC_ACC_MOD  = 16'(CTIFC_SYS_KHZ);
  localparam logic [15:0] CTIFC_ACC_STEP = 16'(CTIFC_OFF_KHZ);

  // AHB encodings.
  localparam logic [1:0] CTIFC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] CTIFC_HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] CTIFC_HSIZE_WORD    = 3'h2;

  typedef struct packed {
    logic       valid;
    logic [5:0] channel;
    logic [1:0] tag;
  } ctifc_iso_hdr_t;

  typedef struct packed {
    logic        load;
    logic [31:0] time_val;
  } ctifc_cyc_load_t;

endpackage

// ---- tb/ctifc_regs_sva.sv ----
// Purpose: Port-level checks for the cycle timer, filter and queue register bank.
// Assumes: One clock domain, reset active low.
// Notes:   Bound to every instance of the register bank.
`timescale 1ns/10ps
`default_nettype none

module ctifc_regs_sva
  import ctifc_pkg::*;
(
  // Clock and bus
  input wire logic           i_clk_sys,
  input wire logic           i_rst_b,
  input wire logic           i_ce,
  input wire logic           i_hsel,
  input wire logic [1:0]     i_htrans,
  input wire logic           i_hwrite,
  input wire logic           i_hready,
  input wire logic [31:0]    o_hrdata,
  input wire logic           o_hreadyout,
  input wire logic           o_hresp,
  // Results
  input wire ctifc_iso_hdr_t i_iso_hdr,
  input wire logic           o_iso_accept,
  input wire logic [1:0]     o_iso_port_hit,
  input wire logic           o_flush_async_tx_queue,
  input wire logic           o_flush_iso_tx_queue,
  input wire logic           o_flush_rx_queue,
  input wire logic [11:0]    o_general_rx_queue_size,
  input wire logic [31:0]    o_bus_cycle_time,
  input wire logic           o_cycle_tick
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  chk_resp_okay: assert property (o_hresp == 1'b0)
    else $error("Bus response was not OKAY.");
  chk_ready_stays: assert property ($past(o_hreadyout) |-> o_hreadyout)
    else $error("Ready dropped after going high.");
  chk_rdata_cause: assert property (o_hrdata != 32'h0 |-> $past(i_hsel && i_hready && i_htrans[1] && !i_hwrite && i_ce))
    else $error("Read data outside a read data phase.");
  chk_flush_async: assert property (o_flush_async_tx_queue |=> !o_flush_async_tx_queue)
    else $error("Async transmit flush held too long.");
  chk_flush_iso: assert property (o_flush_iso_tx_queue |=> !o_flush_iso_tx_queue)
    else $error("Iso transmit flush held too long.");
  chk_flush_rx: assert property (o_flush_rx_queue |=> !o_flush_rx_queue)
    else $error("Receive flush held too long.");
  chk_accept_cause: assert property (o_iso_accept |-> $past(i_iso_hdr.valid))
    else $error("Accept without a packet header.");
  chk_hit_accepts: assert property (o_iso_port_hit != 2'h0 |-> o_iso_accept)
    else $error("Port hit without accept.");
  chk_rx_size_cap: assert property (o_general_rx_queue_size <= 12'hA00)
    else $error("Receive queue size above total.");
  chk_time_fields: assert property (o_bus_cycle_time[11:0] <= 12'hBFF && o_bus_cycle_time[24:12] <= 13'h1F3F)
    else $error("Cycle time field out of range.");
  chk_tick_pulse: assert property (o_cycle_tick |=> !o_cycle_tick)
    else $error("Cycle tick held longer than one cycle.");
endmodule // ctifc_regs_sva

bind ctifc_regs ctifc_regs_sva u_sva (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_hsel(i_hsel),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
  .o_hresp(o_hresp), .i_iso_hdr(i_iso_hdr), .o_iso_accept(o_iso_accept), .o_iso_port_hit(o_iso_port_hit),
  .o_flush_async_tx_queue(o_flush_async_tx_queue), .o_flush_iso_tx_queue(o_flush_iso_tx_queue),
  .o_flush_rx_queue(o_flush_rx_queue), .o_general_rx_queue_size(o_general_rx_queue_size),
  .o_bus_cycle_time(o_bus_cycle_time), .o_cycle_tick(o_cycle_tick));

`default_nettype wire

// ---- tb/ctifc_regs_tb.sv ----
// Purpose: Self-checking bench for the cycle timer, filter and queue register bank.
// Assumes: Clock enable held high and the external cycle pin idle.
// Notes:   Drivers queue expectations; one monitor compares them when look is high.
`timescale 1ns/10ps
`default_nettype none

module ctifc_regs_tb;
  import ctifc_pkg::*;
  logic            clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, look = 1'b0, rdy, acc;
  logic [31:0]     haddr = '0, hwdata = '0, rdata, ctime, seed = 32'h6D04, base, got, e;
  logic [1:0]      htrans = '0, hit;
  logic [2:0]      hsize = CTIFC_HSIZE_WORD, sel = '0, fl;
  logic [11:0]     rxsz;
  ctifc_iso_hdr_t  hdr = '0;
  ctifc_cyc_load_t cst = '0;
  logic [31:0]     exp_q[$];
  int              n_mismatch = 0, comparisons = 0;

  always #10 clk = ~clk;

  ctifc_regs uut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_ce(1'b1), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(rdy), .o_hrdata(rdata), .o_hreadyout(rdy),
    .o_hresp(), .i_ext_cycle(1'b0), .i_cycle_start(cst), .i_iso_hdr(hdr), .o_iso_accept(acc), .o_iso_port_hit(hit),
    .o_flush_async_tx_queue(fl[2]), .o_flush_iso_tx_queue(fl[1]), .o_flush_rx_queue(fl[0]),
    .o_general_rx_queue_size(rxsz), .o_bus_cycle_time(ctime), .o_cycle_tick());

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] obs(input logic [2:0] s);
    case (s)
      3'h1: return {20'h0, rxsz};
      3'h2: return {29'h0, fl};
      3'h3: return {29'h0, acc, hit};
      3'h4: return {31'h0, acc};
      3'h5: return {12'h0, ctime[31:12]};
      default: return rdata;
    endcase
  endfunction

  // Address phase held until ready, then data phase held until ready; reads are judged at that last edge.
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d, input logic [2:0] sz,
                     input logic [31:0] ex);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= CTIFC_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= sz;
    do @(posedge clk); while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!wr)
    begin
      exp_q.push_back(ex);
      sel <= 3'h0;
      look <= 1'b1;
    end
    do @(posedge clk); while (rdy !== 1'b1);
    if (!wr)
      look <= 1'b0;
  endtask

  task automatic see(input logic [2:0] s, input logic [31:0] ex);
    exp_q.push_back(ex);
    sel <= s;
    look <= 1'b1;
    @(posedge clk);
    look <= 1'b0;
  endtask

  task automatic iso(input logic [5:0] ch, input logic [1:0] tg, input logic [2:0] s, input logic [31:0] ex);
    @(posedge clk);
    hdr <= '{1'b1, ch, tg};
    @(posedge clk);
    hdr.valid <= 1'b0;
    see(s, ex);
  endtask

  task automatic complete_run();
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk)
  begin
    if (look === 1'b1)
    begin
      got = obs(sel);
      e = exp_q.pop_front();
      comparisons++;
      if (got !== e)
      begin
        $display("MISMATCH t=%0t exp=%h got=%h", $time, e, got);
        n_mismatch++;
      end
    end
  end

  initial
  begin
    #200us;
    n_mismatch++;
    complete_run();
  end

  initial
  begin : main
    logic [31:0] r;
    logic        h1, h2;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    bus(CTIFC_OFS_CYCLE, 1'b0, 0, 3'h2, CTIFC_RST_CYCLE);
    bus(CTIFC_OFS_FILTER, 1'b0, 0, 3'h2, CTIFC_RST_FILTER);
    bus(CTIFC_OFS_QUEUE, 1'b0, 0, 3'h2, 32'h07FD_3299);
    bus(8'h40, 1'b0, 0, 3'h2, 32'h0);
    for (int k = 0; k < 3; k++)
    begin
      base = xs() & 32'h07FF_FFFF;
      bus(CTIFC_OFS_QUEUE, 1'b1, base, 3'h2, 0);
      bus(CTIFC_OFS_QUEUE, 1'b0, 0, 3'h2, base);
      repeat (2) @(posedge clk);
      see(3'h1, 32'd2560 - base[17:9] - base[8:0]);
      bus(CTIFC_OFS_QUEUE, 1'b1, base | (32'h8000_0000 >> k), 3'h2, 0);
      see(3'h2, 32'h4 >> k);
      bus(CTIFC_OFS_QUEUE, 1'b0, 0, 3'h2, base);
    end
    base = xs() & 32'hFFFF_0001;
    bus(CTIFC_OFS_FILTER, 1'b1, base, 3'h2, 0);
    bus(CTIFC_OFS_FILTER, 1'b1, ~base, 3'h0, 0);
    bus(CTIFC_OFS_FILTER, 1'b0, 0, 3'h2, base);
    // Port one listens on channel 5 with tag 1, port two on channel 9 with tag 2.
    for (int c = 0; c < 8; c++)
    begin
      bus(CTIFC_OFS_FILTER, 1'b1, 32'h4589_0000 | c[2], 3'h2, 0);
      bus(CTIFC_OFS_CONTROL, 1'b1, {26'h0, c[1:0], 4'h0}, 3'h2, 0);
      repeat (6)
      begin
        r = xs();
        r[7:2] = (r[1:0] == 2'h0) ? 6'h5 : (r[1:0] == 2'h1) ? 6'h9 : r[7:2];
        h1 = c[0] && r[7:2] == 6'h5 && (!c[2] || r[9:8] == 2'h1);
        h2 = c[1] && r[7:2] == 6'h9 && (!c[2] || r[9:8] == 2'h2);
        iso(r[7:2], r[9:8], 3'h3, {29'h0, h1 | h2, h2, h1});
      end
    end
    bus(CTIFC_OFS_CONTROL, 1'b1, 32'h8, 3'h2, 0);
    r = xs();
    iso(r[5:0], r[7:6], 3'h4, 32'h1);
    bus(CTIFC_OFS_CYCLE, 1'b1, 32'hFFF3_FBFE, 3'h2, 0);
    bus(CTIFC_OFS_CYCLE, 1'b0, 0, 3'h2, 32'hFFF3_FBFE);
    bus(CTIFC_OFS_CONTROL, 1'b1, 32'h3, 3'h2, 0);
    repeat (20) @(posedge clk);
    see(3'h5, 32'h0);
    bus(CTIFC_OFS_CONTROL, 1'b1, 32'h1, 3'h2, 0);
    @(posedge clk);
    cst <= '{1'b1, 32'h0240_0000};
    @(posedge clk);
    cst.load <= 1'b0;
    repeat (3) @(posedge clk);
    see(3'h5, 32'h0000_2400);
    complete_run();
  end
endmodule // ctifc_regs_tb

`default_nettype wire
